// ### rtl/nnx_pkg.sv
package nnx_pkg;
	// Datapath widths
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ACC_W = 40;
	localparam int unsigned INSTR_W = 24;
	localparam int unsigned NREG = 16;
	localparam int unsigned NEV = 5;
	// Opcode byte in bits 23:16 and fixed tails
	localparam int unsigned F_OPB_LSB = 16;
	localparam logic [7:0] OPB_REG_NEG = 8'hEA;
	localparam logic [7:0] OPB_ACC_NEG = 8'hCB;
	localparam logic [7:0] OPB_EXP_SHIFT = 8'hCE;
	localparam logic [7:0] OPB_IDLE = 8'h00;
	localparam logic [7:0] OPB_ALT_IDLE = 8'hFF;
	localparam logic [14:0] ACC_NEG_TAIL = 15'h1000;
	localparam logic [7:0] EXP_SHIFT_MID = 8'hC0;
	// Instruction field positions
	localparam int unsigned F_SEL = 15;
	localparam int unsigned F_SIZE = 14;
	localparam int unsigned F_RQ_LSB = 11;
	localparam int unsigned F_RD_LSB = 7;
	localparam int unsigned F_RP_LSB = 4;
	localparam int unsigned F_RS_LSB = 0;
	localparam int unsigned F_NQ_LSB = 4;
	localparam int unsigned F_ND_LSB = 0;
	localparam int unsigned F_MID_LSB = 7;
	// Status register bit positions
	localparam int unsigned SR_C = 0;
	localparam int unsigned SR_Z = 1;
	localparam int unsigned SR_OV = 2;
	localparam int unsigned SR_N = 3;
	localparam int unsigned SR_DC = 8;
	localparam int unsigned SR_SAB = 10;
	localparam int unsigned SR_OAB = 11;
	localparam int unsigned SR_SB = 12;
	localparam int unsigned SR_SA = 13;
	localparam int unsigned SR_OB = 14;
	localparam int unsigned SR_OA = 15;
	// Event bit positions
	localparam int unsigned EV_REG_NEG = 0;
	localparam int unsigned EV_ACC_NEG = 1;
	localparam int unsigned EV_EXP = 2;
	localparam int unsigned EV_IDLE = 3;
	localparam int unsigned EV_BAD = 4;
	// Register byte offsets
	localparam logic [11:0] REG_SR = 12'h000;
	localparam logic [11:0] REG_WIDX = 12'h004;
	localparam logic [11:0] REG_WDATA = 12'h008;
	localparam logic [11:0] REG_MIDX = 12'h00C;
	localparam logic [11:0] REG_MDATA = 12'h010;
	localparam logic [11:0] REG_FIRST_ACCUMULATOR_LO = 12'h014;
	localparam logic [11:0] REG_FIRST_ACCUMULATOR_HI = 12'h018;
	localparam logic [11:0] REG_SECOND_ACCUMULATOR_LO = 12'h01C;
	localparam logic [11:0] REG_SECOND_ACCUMULATOR_HI = 12'h020;
	localparam logic [11:0] REG_EV_STAT = 12'h024;
	localparam logic [11:0] REG_EV_EN = 12'h028;
	localparam logic [11:0] REG_EV_CLR = 12'h02C;
	// Arithmetic constants
	localparam logic [DATA_W-1:0] STEP_BYTE = 16'h0001;
	localparam logic [DATA_W-1:0] STEP_WORD = 16'h0002;
	localparam logic [ACC_W-1:0] ACC_ONE = 40'h00_0000_0001;
	localparam logic [ACC_W-1:0] ACC_MIN = 40'h80_0000_0000;
	localparam logic [5:0] EXPONENT_SHIFT_OP_SIGN_BITS = 6'h09;
	localparam logic [5:0] EXPONENT_SHIFT_OP_ALL_BITS = 6'h28;
	// Addressing modes
	typedef enum logic [2:0] {
		AM_DIRECT = 3'b000,
		AM_IND = 3'b001,
		AM_POSTDEC = 3'b010,
		AM_POSTINC = 3'b011,
		AM_PREDEC = 3'b100,
		AM_PREINC = 3'b101
	} nnx_am_e;
	// Decoded operations
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_REG_NEG = 3'b001,
		OP_ACC_NEG = 3'b010,
		OP_EXP = 3'b011,
		OP_IDLE = 3'b100,
		OP_ALT_IDLE = 3'b101,
		OP_BAD = 3'b110
	} nnx_op_e;
endpackage : nnx_pkg

// ### rtl/nnx_neg_unit.sv
`timescale 1ns/1ps
module nnx_neg_unit import nnx_pkg::*; (
	input wire logic [DATA_W-1:0] i_opnd, // Operand, byte in low bits
	input wire logic i_byte, // High for byte width
	output logic [DATA_W-1:0] o_res, // Inverse plus one
	output logic o_c, // Carry out of the top bit
	output logic o_dc, // Carry out of the low nibble
	output logic o_ov, // Signed overflow
	output logic o_n, // Result sign
	output logic o_z // Result is zero
);
	logic [DATA_W:0] sum_w; // Word sum with carry
	logic [8:0] sum_b; // Byte sum with carry

	////////////////////////////////////////////////////////////////////////
	// Inverse plus one in both widths, then pick by size
	always_comb begin
		sum_w = {1'b0, ~i_opnd} + 17'h0_0001;
		sum_b = {1'b0, ~i_opnd[7:0]} + 9'h001;
		o_dc = (i_opnd[3:0] == 4'h0);
		if (i_byte) begin
			o_res = {8'h00, sum_b[7:0]};
			o_c = sum_b[8];
			o_n = sum_b[7];
			o_ov = sum_b[7] & i_opnd[7]; // Only the most negative byte
			o_z = (sum_b[7:0] == 8'h00);
		end else begin
			o_res = sum_w[DATA_W-1:0];
			o_c = sum_w[DATA_W];
			o_n = sum_w[DATA_W-1];
			o_ov = sum_w[DATA_W-1] & i_opnd[DATA_W-1];
			o_z = (sum_w[DATA_W-1:0] == 16'h0000);
		end
	end
endmodule : nnx_neg_unit

// ### rtl/nnx_exponent_shift_op_unit.sv
`timescale 1ns/1ps
module nnx_exponent_shift_op_unit import nnx_pkg::*; (
	input wire logic [ACC_W-1:0] i_acc, // Accumulator to normalize
	output logic [ACC_W-1:0] o_acc, // Normalized value
	output logic [DATA_W-1:0] o_exp, // Signed shift, positive means right
	output logic o_shift // High when a shift was needed
);
	logic [5:0] lead; // Count of leading bits equal to the sign
	logic run; // Still inside the leading run

	////////////////////////////////////////////////////////////////////////
	// Sign run length; nine equal top bits is normalized
	always_comb begin
		lead = 6'h01;
		run = 1'b1;
		for (int i = ACC_W - 2; i >= 0; i--) begin
			if (run && (i_acc[i] == i_acc[ACC_W-1])) begin
				lead = lead + 6'h01;
			end else begin
				run = 1'b0;
			end
		end
		o_shift = (lead != EXPONENT_SHIFT_OP_SIGN_BITS) && (lead != EXPONENT_SHIFT_OP_ALL_BITS);
		o_exp = {10'h000, EXPONENT_SHIFT_OP_SIGN_BITS} - {10'h000, lead};
		if (!o_shift) begin
			o_acc = i_acc; // Already normal or all sign bits
			o_exp = 16'h0000;
		end else if (lead < EXPONENT_SHIFT_OP_SIGN_BITS) begin
			o_acc = ACC_W'($signed(i_acc) >>> (EXPONENT_SHIFT_OP_SIGN_BITS - lead)); // Remove overflow
		end else begin
			o_acc = i_acc << (lead - EXPONENT_SHIFT_OP_SIGN_BITS); // Grow fraction
		end
	end
endmodule : nnx_exponent_shift_op_unit

// ### rtl/nnx_exec.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// RQ1: Decode register negate with mode and register fields
// RQ2: Register negate writes inverse plus one, flags
// RQ3: Size bit zero word, one byte
// RQ4: Direct or indirect, pre/post inc/dec pointers
// RQ5: Register negate finishes in one cycle
// RQ6: Decode accumulator negate with select bit
// RQ7: Accumulator negate over all 40 bits
// RQ8: Accumulator negate updates overflow and clip flags
// RQ9: Zero upper byte is a one-cycle idle
// RQ10: All-ones upper byte is a one-cycle idle
// RQ11: Decode normalize with select, mode, register
// RQ12: Overflowed accumulator shifts right minimally
// RQ13: Clean accumulator shifts left to fraction limit
// RQ14: Nothing to shift: write zero, Z set, N clear
// RQ15: Shift count written signed, N from sign
// RQ16: Normalize leaves target overflow flag cleared
// RQ17: Normalize never touches the clip sticky flag
// RQ18: Pointer step one for bytes, two for words
module nnx_exec import nnx_pkg::*; #(
	parameter int unsigned MEM_WORDS = 64 // Data memory depth in words
) (
	input wire logic i_clk, // Core clock
	input wire logic i_arst_n, // Asynchronous reset, active low
	input wire logic i_instr_valid, // Instruction issued this cycle
	input wire logic [INSTR_W-1:0] i_instr, // Instruction word
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB write
	input wire logic [11:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error on unmapped address
	output logic o_done, // Instruction retired pulse
	output logic o_irq // Enabled event pending
);
	localparam int unsigned MA_W = $clog2(MEM_WORDS);

	// Refuse depths the byte addressing cannot serve
	if ((MEM_WORDS < 2) || (MEM_WORDS > 32768) || ((MEM_WORDS & (MEM_WORDS - 1)) != 0))
	begin : g_bad_depth
		$error("MEM_WORDS must be a power of two from 2 to 32768");
	end

	typedef logic [MEM_WORDS-1:0][DATA_W-1:0] nnx_mem_t;

	typedef struct packed {
		logic [NREG-1:0][DATA_W-1:0] w; // Working registers
		nnx_mem_t mem; // Data memory
		logic [ACC_W-1:0] acc_a; // First accumulator
		logic [ACC_W-1:0] acc_b; // Second accumulator
		logic [DATA_W-1:0] sr; // Status flags
		logic [3:0] widx; // Register window index
		logic [MA_W-1:0] midx; // Memory window index
		logic [NEV-1:0] ev_stat; // Sticky events
		logic [NEV-1:0] ev_en; // Event enables
		logic done; // Retire pulse
		logic irq; // Interrupt level
		logic [31:0] prdata; // Bus read data
		logic pready; // Bus ready
		logic pslverr; // Bus error
	} nnx_state_s;

	nnx_state_s st_r; // Registered state
	nnx_state_s st_n; // Next state

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Classify the issued word
	function automatic nnx_op_e op_decode(input logic v, input logic [INSTR_W-1:0] ins);
		logic [7:0] opb;
		opb = ins[F_OPB_LSB +: 8];
		if (!v) return OP_NONE;
		if (opb == OPB_IDLE) return OP_IDLE; // RQ9
		if (opb == OPB_ALT_IDLE) return OP_ALT_IDLE; // RQ10
		if ((opb == OPB_REG_NEG) && !ins[F_SEL]) return OP_REG_NEG; // RQ1
		if ((opb == OPB_ACC_NEG) && (ins[14:0] == ACC_NEG_TAIL)) return OP_ACC_NEG; // RQ6
		if ((opb == OPB_EXP_SHIFT) && (ins[F_MID_LSB +: 8] == EXP_SHIFT_MID)) return OP_EXP; // RQ11
		return OP_BAD;
	endfunction : op_decode

	// Address used by an indirect access
	function automatic logic [DATA_W-1:0] ea(input nnx_am_e m, input logic [DATA_W-1:0] p,
		input logic [DATA_W-1:0] s);
		unique case (m)
			AM_PREDEC: return p - s; // RQ4
			AM_PREINC: return p + s; // RQ4
			default: return p;
		endcase
	endfunction : ea

	// Pointer value after the access
	function automatic logic [DATA_W-1:0] ptr_next(input nnx_am_e m, input logic [DATA_W-1:0] p,
		input logic [DATA_W-1:0] s);
		unique case (m)
			AM_POSTDEC, AM_PREDEC: return p - s; // RQ18
			AM_POSTINC, AM_PREINC: return p + s; // RQ18
			default: return p;
		endcase
	endfunction : ptr_next

	// Byte or word read, byte zero-extended
	function automatic logic [DATA_W-1:0] mem_rd(input nnx_mem_t m, input logic [DATA_W-1:0] a,
		input logic b);
		logic [DATA_W-1:0] wd;
		wd = m[a[MA_W:1]];
		if (!b) return wd;
		return {8'h00, a[0] ? wd[15:8] : wd[7:0]};
	endfunction : mem_rd

	// Byte or word write into a copy of memory
	function automatic nnx_mem_t mem_wr(input nnx_mem_t m, input logic [DATA_W-1:0] a,
		input logic b, input logic [DATA_W-1:0] d);
		nnx_mem_t r;
		r = m;
		if (!b) begin
			r[a[MA_W:1]] = d;
		end else if (a[0]) begin
			r[a[MA_W:1]][15:8] = d[7:0];
		end else begin
			r[a[MA_W:1]][7:0] = d[7:0];
		end
		return r;
	endfunction : mem_wr

	// Top nine bits disagree
	function automatic logic acc_ovf(input logic [ACC_W-1:0] a);
		return !((&a[ACC_W-1:31]) || (~|a[ACC_W-1:31]));
	endfunction : acc_ovf

	////////////////////////////////////////////////////////////////////////
	// Source operand fetch and arithmetic units
	nnx_op_e op; // Decoded operation
	logic bsz; // Byte size
	logic [3:0] rs; // Source register
	nnx_am_e sm; // Source mode
	logic [DATA_W-1:0] step; // Pointer step
	logic [DATA_W-1:0] src_a; // Source address
	logic [DATA_W-1:0] src_ptr_nxt; // Source pointer after access
	logic [DATA_W-1:0] opnd; // Source operand
	logic [ACC_W-1:0] acc_sel; // Selected accumulator
	logic [DATA_W-1:0] neg_res; // Negate result
	logic neg_c, neg_dc, neg_ov, neg_n, neg_z; // Negate flags
	logic [ACC_W-1:0] nrm_acc; // Normalized accumulator
	logic [DATA_W-1:0] nrm_exp; // Shift count
	logic nrm_shift; // Shift needed

	assign op = op_decode(i_instr_valid, i_instr);
	assign bsz = i_instr[F_SIZE]; // RQ3
	assign rs = i_instr[F_RS_LSB +: 4];
	assign sm = nnx_am_e'(i_instr[F_RP_LSB +: 3]);
	assign step = bsz ? STEP_BYTE : STEP_WORD; // RQ18
	assign src_a = ea(sm, st_r.w[rs], step);
	assign src_ptr_nxt = ptr_next(sm, st_r.w[rs], step);
	assign opnd = (sm == AM_DIRECT) ? (bsz ? {8'h00, st_r.w[rs][7:0]} : st_r.w[rs])
		: mem_rd(st_r.mem, src_a, bsz); // RQ4
	assign acc_sel = i_instr[F_SEL] ? st_r.acc_b : st_r.acc_a;

	nnx_neg_unit u_neg (
		.i_opnd(opnd),
		.i_byte(bsz),
		.o_res(neg_res),
		.o_c(neg_c),
		.o_dc(neg_dc),
		.o_ov(neg_ov),
		.o_n(neg_n),
		.o_z(neg_z)
	);

	nnx_exponent_shift_op_unit u_exponent_shift_op (
		.i_acc(acc_sel),
		.o_acc(nrm_acc),
		.o_exp(nrm_exp),
		.o_shift(nrm_shift)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state: bus access first, then the instruction
	always_comb begin : p_next
		logic [3:0] dd;
		nnx_am_e dm;
		logic [DATA_W-1:0] dv;
		logic [DATA_W-1:0] da;
		logic dbyte;
		logic den;
		logic acc_op;
		logic ar;
		logic aw;
		logic [NEV-1:0] ev;
		logic [NEV-1:0] clr;
		logic [ACC_W-1:0] acc_new;
		dd = 4'h0;
		dm = AM_DIRECT;
		dv = '0;
		da = '0;
		dbyte = 1'b0;
		den = 1'b0;
		acc_op = 1'b0;
		ev = '0;
		clr = '0;
		acc_new = '0;
		st_n = st_r;
		// Two-cycle access phase: ready one cycle after enable
		ar = i_psel & i_penable & ~st_r.pready;
		aw = ar & i_pwrite;
		st_n.pready = ar;
		st_n.pslverr = 1'b0;
		if (ar) begin
			st_n.prdata = '0;
			unique case (i_paddr)
				REG_SR: begin
					st_n.prdata[DATA_W-1:0] = st_r.sr;
					if (aw) st_n.sr = i_pwdata[DATA_W-1:0];
				end
				REG_WIDX: begin
					st_n.prdata[3:0] = st_r.widx;
					if (aw) st_n.widx = i_pwdata[3:0];
				end
				REG_WDATA: begin
					st_n.prdata[DATA_W-1:0] = st_r.w[st_r.widx];
					if (aw) st_n.w[st_r.widx] = i_pwdata[DATA_W-1:0];
				end
				REG_MIDX: begin
					st_n.prdata[MA_W-1:0] = st_r.midx;
					if (aw) st_n.midx = i_pwdata[MA_W-1:0];
				end
				REG_MDATA: begin
					st_n.prdata[DATA_W-1:0] = st_r.mem[st_r.midx];
					if (aw) st_n.mem[st_r.midx] = i_pwdata[DATA_W-1:0];
				end
				REG_FIRST_ACCUMULATOR_LO: begin
					st_n.prdata = st_r.acc_a[31:0];
					if (aw) st_n.acc_a[31:0] = i_pwdata;
				end
				REG_FIRST_ACCUMULATOR_HI: begin
					st_n.prdata[7:0] = st_r.acc_a[ACC_W-1:32];
					if (aw) st_n.acc_a[ACC_W-1:32] = i_pwdata[7:0];
				end
				REG_SECOND_ACCUMULATOR_LO: begin
					st_n.prdata = st_r.acc_b[31:0];
					if (aw) st_n.acc_b[31:0] = i_pwdata;
				end
				REG_SECOND_ACCUMULATOR_HI: begin
					st_n.prdata[7:0] = st_r.acc_b[ACC_W-1:32];
					if (aw) st_n.acc_b[ACC_W-1:32] = i_pwdata[7:0];
				end
				REG_EV_STAT: st_n.prdata[NEV-1:0] = st_r.ev_stat;
				REG_EV_EN: begin
					st_n.prdata[NEV-1:0] = st_r.ev_en;
					if (aw) st_n.ev_en = i_pwdata[NEV-1:0];
				end
				REG_EV_CLR: begin
					if (aw) clr = i_pwdata[NEV-1:0];
				end
				default: st_n.pslverr = 1'b1; // Unmapped
			endcase
		end
		// Execute the issued instruction in this one cycle
		unique case (op)
			OP_REG_NEG: begin
				st_n.w[rs] = src_ptr_nxt; // RQ4
				dd = i_instr[F_RD_LSB +: 4];
				dm = nnx_am_e'(i_instr[F_RQ_LSB +: 3]);
				dv = neg_res; // RQ2
				dbyte = bsz; // RQ3
				den = 1'b1;
				st_n.sr[SR_C] = neg_c; // RQ2
				st_n.sr[SR_DC] = neg_dc;
				st_n.sr[SR_OV] = neg_ov;
				st_n.sr[SR_N] = neg_n;
				st_n.sr[SR_Z] = neg_z;
				ev[EV_REG_NEG] = 1'b1;
			end
			OP_ACC_NEG: begin
				acc_new = ~acc_sel + ACC_ONE; // RQ7
				acc_op = 1'b1;
				if (i_instr[F_SEL]) begin
					st_n.acc_b = acc_new;
					if (acc_sel == ACC_MIN) st_n.sr[SR_SB] = 1'b1; // RQ8
				end else begin
					st_n.acc_a = acc_new;
					if (acc_sel == ACC_MIN) st_n.sr[SR_SA] = 1'b1; // RQ8
				end
				ev[EV_ACC_NEG] = 1'b1;
			end
			OP_EXP: begin
				if (i_instr[F_SEL]) begin
					st_n.acc_b = nrm_acc; // RQ12 RQ13
				end else begin
					st_n.acc_a = nrm_acc; // RQ12 RQ13
				end
				acc_op = 1'b1;
				dd = i_instr[F_ND_LSB +: 4];
				dm = nnx_am_e'(i_instr[F_NQ_LSB +: 3]);
				dv = nrm_exp; // RQ14 RQ15
				den = 1'b1;
				st_n.sr[SR_N] = nrm_exp[DATA_W-1]; // RQ15
				st_n.sr[SR_Z] = ~nrm_shift; // RQ14
				ev[EV_EXP] = 1'b1;
			end
			OP_IDLE, OP_ALT_IDLE: ev[EV_IDLE] = 1'b1; // RQ9 RQ10
			OP_BAD: ev[EV_BAD] = 1'b1;
			OP_NONE: ;
		endcase
		// Destination write, pointer moved before the direct write
		if (den) begin
			da = ea(dm, st_n.w[dd], dbyte ? STEP_BYTE : STEP_WORD); // RQ4
			st_n.w[dd] = ptr_next(dm, st_n.w[dd], dbyte ? STEP_BYTE : STEP_WORD); // RQ18
			if (dm == AM_DIRECT) begin
				st_n.w[dd] = dbyte ? {st_n.w[dd][15:8], dv[7:0]} : dv; // RQ3
			end else begin
				st_n.mem = mem_wr(st_n.mem, da, dbyte, dv);
			end
		end
		// Overflow flags follow the accumulator contents
		if (acc_op) begin
			st_n.sr[SR_OA] = acc_ovf(st_n.acc_a); // RQ8 RQ16
			st_n.sr[SR_OB] = acc_ovf(st_n.acc_b); // RQ8 RQ16
			st_n.sr[SR_OAB] = st_n.sr[SR_OA] | st_n.sr[SR_OB]; // RQ8
			st_n.sr[SR_SAB] = st_n.sr[SR_SA] | st_n.sr[SR_SB]; // RQ8
		end
		st_n.done = (op != OP_NONE); // RQ5
		st_n.ev_stat = (st_r.ev_stat & ~clr) | ev; // New event beats clear
		st_n.irq = |(st_n.ev_stat & st_n.ev_en);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_n;
		end
	end

	assign o_prdata = st_r.prdata;
	assign o_pready = st_r.pready;
	assign o_pslverr = st_r.pslverr;
	assign o_done = st_r.done;
	assign o_irq = st_r.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic apb_wr; // Bus write in flight
	logic [3:0] rd_neg; // Negate destination register
	logic [3:0] rd_exp; // Normalize destination register
	logic dm0; // Negate destination direct
	assign apb_wr = i_psel & i_penable & i_pwrite;
	assign rd_neg = i_instr[F_RD_LSB +: 4];
	assign rd_exp = i_instr[F_ND_LSB +: 4];
	assign dm0 = (i_instr[F_RQ_LSB +: 3] == 3'b000);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	AST_NEG_WORD: assert property (op == OP_REG_NEG && !bsz && dm0 && !apb_wr // RQ2
		|=> st_r.w[$past(rd_neg)] == 16'h0000 - $past(opnd)) else $error("word negate wrong");
	AST_NEG_BYTE_HIGH: assert property (op == OP_REG_NEG && bsz && dm0 && !apb_wr // RQ3
		&& rs != rd_neg |=> st_r.w[$past(rd_neg)][15:8] == $past(st_r.w[rd_neg][15:8]))
		else $error("byte negate touched upper byte");
	AST_NEG_FLAG_Z: assert property (op == OP_REG_NEG && !apb_wr && opnd == 16'h0000 // RQ2
		|=> st_r.sr[SR_Z] && st_r.sr[SR_C]) else $error("negate of zero flags wrong");
	AST_ONE_CYCLE: assert property (i_instr_valid |=> o_done) // RQ5
		else $error("instruction did not retire in one cycle");
	AST_ACC_NEG: assert property (op == OP_ACC_NEG && !i_instr[F_SEL] && !apb_wr // RQ7
		|=> st_r.acc_a == ACC_W'(40'h00_0000_0000 - $past(st_r.acc_a)))
		else $error("accumulator negate wrong");
	AST_ACC_FLAGS: assert property (op == OP_ACC_NEG // RQ8
		|=> st_r.sr[SR_OAB] == (st_r.sr[SR_OA] | st_r.sr[SR_OB])
		&& st_r.sr[SR_OB] == acc_ovf(st_r.acc_b)) else $error("accumulator flags wrong");
	AST_IDLE: assert property ((op == OP_IDLE || op == OP_ALT_IDLE) && !apb_wr // RQ9
		|=> $stable(st_r.w) && $stable(st_r.sr) && $stable(st_r.acc_a))
		else $error("idle changed state");
	AST_ALT_IDLE_MEM: assert property (op == OP_ALT_IDLE && !apb_wr // RQ10
		|=> $stable(st_r.mem) && $stable(st_r.acc_b)) else $error("alternate idle changed state");
	AST_EXP_NONE: assert property (op == OP_EXP && !nrm_shift && !apb_wr // RQ14
		&& i_instr[F_NQ_LSB +: 3] == 3'b000 |=> st_r.sr[SR_Z] && !st_r.sr[SR_N]
		&& st_r.w[$past(rd_exp)] == 16'h0000) else $error("normalize no-shift wrong");
	AST_EXP_RIGHT: assert property (op == OP_EXP && acc_ovf(acc_sel) // RQ12
		|=> !st_r.sr[SR_N] && !st_r.sr[SR_Z]) else $error("right shift sign wrong");
	AST_EXP_OVF: assert property (op == OP_EXP && !apb_wr // RQ16
		|=> !($past(i_instr[F_SEL]) ? st_r.sr[SR_OB] : st_r.sr[SR_OA]))
		else $error("overflow left set");
	AST_EXP_STICKY: assert property (op == OP_EXP && !apb_wr // RQ17
		|=> $stable(st_r.sr[SR_SA]) && $stable(st_r.sr[SR_SB])) else $error("sticky changed");
	AST_PTR_STEP: assert property (op == OP_REG_NEG && sm == AM_POSTINC && dm0 // RQ18
		&& rs != rd_neg && !apb_wr |=> st_r.w[$past(rs)] == $past(st_r.w[rs]) + $past(step))
		else $error("pointer step wrong");
	AST_IRQ: assert property (st_r.ev_stat != '0 && st_r.ev_en == 5'h1F |-> o_irq)
		else $error("interrupt not raised");

	COV_BYTE_NEG: cover property (op == OP_REG_NEG && bsz ##1 o_done);
	COV_ACC_CLIP: cover property (op == OP_ACC_NEG && acc_sel == ACC_MIN);
	COV_EXP_LEFT: cover property (op == OP_EXP && nrm_shift && !acc_ovf(acc_sel));
	COV_IRQ: cover property (o_irq ##1 !o_irq);
endmodule : nnx_exec

// ### bench/nnx_issue_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Front end model: issues one word and reports whether it retired
module nnx_issue_model import nnx_pkg::*; (
	input wire logic i_clk, // Core clock
	input wire logic i_done, // Retire pulse from the datapath
	output logic o_valid, // Instruction issued
	output logic [INSTR_W-1:0] o_instr // Instruction word
);
	// Quiet until the bench asks for an issue
	initial begin
		o_valid = 1'b0;
		o_instr = 24'h000000;
	end
	// One word for one cycle; the retire pulse must follow at the next edge
	task automatic issue(input logic [INSTR_W-1:0] w, output logic ok);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_instr <= w;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_instr <= ~w; // Stale word scrambled so it is never reused
		#1;
		ok = i_done;
	endtask : issue
endmodule : nnx_issue_model

// ### bench/negate_normalize_nop_exec_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
////////////////////////////////////////
module negate_normalize_nop_exec_tb import nnx_pkg::*; ;
	logic i_clk = 1'b0; // Core clock
	logic i_arst_n = 1'b0; // Reset, active low
	logic valid, done, irq, pready, pslverr, ok; // Handshakes
	logic [INSTR_W-1:0] instr; // Issued word
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
	logic [11:0] paddr = 12'h000; // APB address
	logic [31:0] pwdata = 32'h00000000, prdata, rd_d, sr0; // APB data
	int fail_count = 0, cmp_count = 0; // Tallies
	// Clock
	always #5 i_clk = ~i_clk;
	nnx_exec #(.MEM_WORDS(4096)) u_nnx_exec (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_instr_valid(valid), .i_instr(instr), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_done(done), .o_irq(irq));
	nnx_issue_model u_nnx_issue_model (.i_clk(i_clk), .i_done(done), .o_valid(valid),
		.o_instr(instr));
	////////////////////////////////////////
	// APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1) @(posedge i_clk);
		rd_d = prdata;
		ok = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd_d, e)
	endtask : chk
	task automatic setw(input logic [31:0] n, input logic [31:0] v);
		wr(REG_WIDX, n);
		wr(REG_WDATA, v);
	endtask : setw
	task automatic chkw(input logic [31:0] n, input logic [31:0] e);
		wr(REG_WIDX, n);
		chk(REG_WDATA, e);
	endtask : chkw
	task automatic srm(input logic [31:0] e);
		apb(1'b0, REG_SR, 32'h0);
		`CHK(rd_d & 32'h0000500A, e)
	endtask : srm
	task automatic run(input logic [INSTR_W-1:0] w);
		u_nnx_issue_model.issue(w, ok);
		`CHK(ok, 1'b1)
	endtask : run
	////////////////////////////////////////
	// Word negate, indirect post-increment source, pre-decrement dest
	task automatic t_word;
		setw(32'h2, 32'h0900);
		setw(32'h4, 32'h1002);
		wr(REG_MIDX, 32'h480);
		wr(REG_MDATA, 32'h870F);
		run(24'hEA2232);
		wr(REG_MIDX, 32'h800);
		chk(REG_MDATA, 32'h78F1);
		chkw(32'h2, 32'h0902);
		chkw(32'h4, 32'h1000);
		chk(REG_SR, 32'h0);
		setw(32'h1, 32'h8000);
		run(24'hEA0081);
		chkw(32'h1, 32'h8000);
		chk(REG_SR, 32'h010C);
	endtask : t_word
	// Byte negate of a zero byte; upper byte of direct dest kept
	task automatic t_byte;
		setw(32'h6, 32'h0A00);
		setw(32'h5, 32'hAB00);
		wr(REG_MIDX, 32'h500);
		wr(REG_MDATA, 32'h1200);
		run(24'hEA42B6);
		chkw(32'h5, 32'hAB00);
		chkw(32'h6, 32'h0A01);
		chk(REG_SR, 32'h0103);
	endtask : t_byte
	// Accumulator negate, including the most negative value
	task automatic t_acc;
		wr(REG_FIRST_ACCUMULATOR_LO, 32'h329059C8);
		wr(REG_FIRST_ACCUMULATOR_HI, 32'h0);
		wr(REG_SECOND_ACCUMULATOR_LO, 32'h0);
		wr(REG_SECOND_ACCUMULATOR_HI, 32'h80);
		wr(REG_SR, 32'h0);
		run(24'hCB1000);
		chk(REG_FIRST_ACCUMULATOR_LO, 32'hCD6FA638);
		chk(REG_FIRST_ACCUMULATOR_HI, 32'hFF);
		run(24'hCB9000);
		chk(REG_SECOND_ACCUMULATOR_HI, 32'h80);
		chk(REG_SR, 32'h5C00);
	endtask : t_acc
	// Normalize left, right, then nothing left to do
	task automatic t_exponent_shift_op;
		run(24'hCE6007);
		chkw(32'h7, 32'hFFFF);
		chk(REG_FIRST_ACCUMULATOR_LO, 32'h9ADF4C70);
		srm(32'h5008);
		run(24'hCEE008);
		chkw(32'h8, 32'h0008);
		chk(REG_SECOND_ACCUMULATOR_HI, 32'hFF);
		srm(32'h1000);
		run(24'hCEE008);
		chkw(32'h8, 32'h0);
		chk(REG_SECOND_ACCUMULATOR_LO, 32'h80000000);
		srm(32'h1002);
	endtask : t_exponent_shift_op
	// Both idle forms change nothing; interrupt raised, masked, cleared
	task automatic t_idle;
		logic [23:0] ws [2];
		ws = '{24'h00ABCD, 24'hFF5A5A};
		wr(REG_EV_CLR, 32'h1F);
		wr(REG_EV_EN, 32'h08);
		apb(1'b0, REG_SR, 32'h0);
		sr0 = rd_d;
		foreach (ws[i]) begin
			run(ws[i]);
			`CHK(irq, 1'b1)
			chk(REG_SR, sr0);
			chkw(32'h8, 32'h0);
		end
		chk(REG_EV_STAT, 32'h08);
		wr(REG_EV_EN, 32'h0);
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(irq, 1'b0)
		wr(REG_EV_CLR, 32'h08);
		chk(REG_EV_STAT, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		`CHK(ok, 1'b1)
	endtask : t_idle
	////////////////////////////////////////
	// Verdict and end of run
	task automatic wrap_up;
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		#200000;
		fail_count++;
		wrap_up;
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge i_clk);
		i_arst_n <= 1'b1;
		t_word;
		t_byte;
		t_acc;
		t_exponent_shift_op;
		t_idle;
		wrap_up;
	end
endmodule : negate_normalize_nop_exec_tb
